/* File: logic/srhb_params.svh */
// Constants of the strip readout hit buffer: timing, offsets, fields.
// Assumes a 20 MHz pclk; included by bare name where needed.
`ifndef SRHB_PARAMS_SVH
`define SRHB_PARAMS_SVH
`define SRHB_NCH        128
`define SRHB_CLK_NS     50
`define SRHB_TS_NS      30
`define SRHB_TS_CYC     (((`SRHB_TS_NS / `SRHB_CLK_NS) > 0) ? \
                         (`SRHB_TS_NS / `SRHB_CLK_NS) : 1)
`define SRHB_LAT_NS     7000
`define SRHB_LAT_CYC    ((`SRHB_LAT_NS + `SRHB_CLK_NS - 1) / `SRHB_CLK_NS)
`define SRHB_TQ_DEPTH   4
`define SRHB_A_CTRL     12'h000
`define SRHB_A_STAT     12'h004
`define SRHB_A_TSNOW    12'h008
`define SRHB_A_PULSE    12'h00c
`define SRHB_A_DIS0     12'h010
`define SRHB_A_INJ0     12'h020
`define SRHB_CTRL_RST   32'h0000_0004
`define SRHB_AMP_DIV0   8'h01
`define SRHB_AMP_DIV1   8'h02
`define SRHB_AMP_DIV2   8'h04
`define SRHB_AMP_DIV3   8'h06
`define SRHB_TYPE_BIT   11
`endif

/* File: logic/srhb_pkg.sv */
// Types shared by the strip readout hit buffer modules.
// Assumes nothing beyond the parameter header.
`include "srhb_params.svh"
package srhb_pkg;
  typedef enum logic [2:0] {
    SRHB_IDLE = 3'b001,
    SRHB_SCAN = 3'b010,
    SRHB_PUSH = 3'b100
  } srhb_state_e;

  typedef struct packed {
    logic [6:0]  strip;
    logic [3:0]  amp;
    logic [9:0]  ts;
    logic [15:0] t;
  } srhb_hit_s;
endpackage : srhb_pkg

/* File: logic/srhb_hit_store.sv */
// Circular store of captured hits with a random-offset read port.
// Assumes DEPTH equals two to the power AW; single pclk domain.
`timescale 1ns/100ps
module srhb_hit_store #(
  parameter int DEPTH = 32,
  parameter int AW    = 5
) (
  input  wire logic                pclk,
  input  wire logic                presetn,
  input  wire logic                push,
  input  wire srhb_pkg::srhb_hit_s wdata,
  input  wire logic                pop,
  input  wire logic [AW-1:0]       rd_off,
  output srhb_pkg::srhb_hit_s      rd_data,
  output srhb_pkg::srhb_hit_s      head,
  output logic [AW:0]              count,
  output logic                     full,
  output logic                     empty
);
  srhb_pkg::srhb_hit_s mem [DEPTH];
  logic [AW-1:0] wp_q;
  logic [AW-1:0] rp_q;
  logic [AW:0]   n_q;
  logic          push_ok;
  logic          pop_ok;
  logic [AW-1:0] ra;

  assign full    = (n_q == (AW+1)'(DEPTH));
  assign empty   = (n_q == '0);
  assign push_ok = push & ~full;
  assign pop_ok  = pop & ~empty;
  assign ra      = rp_q + rd_off;
  assign rd_data = mem[ra];
  assign head    = mem[rp_q];
  assign count   = n_q;

  always_ff @(posedge pclk) begin
    if (push_ok) begin
      mem[wp_q] <= wdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wp_q <= '0;
      rp_q <= '0;
      n_q  <= '0;
    end else begin
      wp_q <= wp_q + AW'(push_ok);
      rp_q <= rp_q + AW'(pop_ok);
      n_q  <= n_q + (AW+1)'(push_ok) - (AW+1)'(pop_ok);
    end
  end
endmodule : srhb_hit_store

/* File: logic/srhb_top.sv */
// Strip readout hit buffer: capture, latency store, trigger match,
// serial output and APB configuration.
// Assumes hit, trig and APB inputs synchronous to pclk.
// Notes on behaviour
// - Keep strip, amplitude, stamp for latency.
// - Trigger sends matches; expired hits dropped.
// - Only hit channels produce output words.
// - 128 independent channels with own capture.
// - Four-bit amplitude from pulse width count.
// - One, two or four serial lanes.
// - One shared stamp counter, one step per 50 ns clock.
// - Stamp and readout timing from system clock.
// - Selectable internal amplitude counting clock.
// - Per channel test charge injection control.
// - Disabled channel captures no new pulses.
// - Triggers queued, accepted back to back.
// - Defaults valid from reset.
// - Written settings kept until overwritten.
// - Every setting reads back.
// - Hit word: strip, amplitude, type, spare.
// - Stamp word: stamp, type, spare.
// - Hits follow their stamp word.
// - Optional push mode streams all hits.
// - Outside push mode, only hits with trigger stamp sent.
// - Output lanes driven from one clock.
`timescale 1ns/100ps
`include "srhb_params.svh"
module srhb_top #(
  parameter int DEPTH = 32,
  parameter int AW    = 5
) (
  input  wire logic           pclk,
  input  wire logic           presetn,
  input  wire logic           psel,
  input  wire logic           penable,
  input  wire logic           pwrite,
  input  wire logic [11:0]    paddr,
  input  wire logic [31:0]    pwdata,
  output logic      [31:0]    prdata,
  output logic                pready,
  output logic                pslverr,
  input  wire logic [127:0]   hit,
  input  wire logic           trig,
  input  wire logic [9:0]     trig_ts,
  output logic      [3:0]     dout,
  output logic                dout_frame,
  output logic                test_charge,
  output logic      [127:0]   inj_mask
);
  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    srhb_pkg::srhb_state_e st;
    logic [127:0]          prev;
    logic [127:0]          act;
    logic [127:0]          pend;
    logic [127:0]          dis;
    logic [127:0]          inj;
    logic [127:0][9:0]     cts;
    logic [127:0][3:0]     cnt;
    logic [9:0]            ts;
    logic [7:0]            tsc;
    logic [7:0]            ampc;
    logic                  amp_tick;
    logic [15:0]           now;
    logic                  push_mode;
    logic [1:0]            lanes;
    logic [1:0]            ampsel;
    logic                  ovf;
    logic                  tlost;
    logic [3:0][9:0]       tq;
    logic [2:0]            tqn;
    logic [AW-1:0]         idx;
    logic [9:0]            last_ts;
    logic                  last_ok;
    logic                  wv;
    logic [15:0]           word;
    logic [15:0]           sr;
    logic [4:0]            bits;
    logic [3:0]            dout;
    logic                  frame;
    logic                  test;
    logic                  pready;
    logic                  pslverr;
    logic [31:0]           prdata;
  } srhb_regs_s;

  srhb_regs_s          q;
  srhb_regs_s          n;
  srhb_pkg::srhb_hit_s wdata;
  srhb_pkg::srhb_hit_s rd;
  srhb_pkg::srhb_hit_s head;
  logic [AW:0]         count;
  logic                full;
  logic                empty;
  logic                push;
  logic                pop;
  logic                found;
  logic [6:0]          sel;
  logic                ovf_set;
  logic                tpop;
  logic                start;
  logic                load_hit;
  logic                expire;
  logic                setup;
  logic                wr;
  logic [7:0]          div;
  logic [2:0]          nl;
  logic [2:0]          tqa;
  logic [31:0]         rdv;
  logic                hit_ok;

  function automatic logic [15:0] hit_word(input logic [6:0] s,
                                           input logic [3:0] a);
    hit_word = {4'h0, 1'b0, a, s};
  endfunction : hit_word

  function automatic logic [15:0] ts_word(input logic [9:0] t);
    ts_word = {4'h0, 1'b1, 1'b0, t};
  endfunction : ts_word

  srhb_hit_store #(
    .DEPTH (DEPTH),
    .AW    (AW)
  ) u_store (
    .pclk    (pclk),
    .presetn (presetn),
    .push    (push),
    .wdata   (wdata),
    .pop     (pop),
    .rd_off  (q.idx),
    .rd_data (rd),
    .head    (head),
    .count   (count),
    .full    (full),
    .empty   (empty)
  );

  assign setup = psel & ~penable;
  assign wr    = psel & penable & pwrite & q.pready;

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    n        = q;
    found    = 1'b0;
    sel      = 7'h00;
    ovf_set  = 1'b0;
    tpop     = 1'b0;
    start    = 1'b0;
    load_hit = 1'b0;
    expire   = 1'b0;
    pop      = 1'b0;
    rdv      = 32'h0000_0000;
    hit_ok   = 1'b0;
    // Stamp counter and amplitude clock divider
    if (q.tsc == 8'(`SRHB_TS_CYC - 1)) begin
      n.tsc = 8'h00;
      n.ts  = q.ts + 10'h001;
    end else begin
      n.tsc = q.tsc + 8'h01;
    end
    n.now = q.now + 16'h0001;
    case (q.ampsel)
      2'h0:    div = `SRHB_AMP_DIV0;
      2'h1:    div = `SRHB_AMP_DIV1;
      2'h2:    div = `SRHB_AMP_DIV2;
      default: div = `SRHB_AMP_DIV3;
    endcase
    n.amp_tick = 1'b0;
    if (q.ampc >= div - 8'h01) begin
      n.ampc     = 8'h00;
      n.amp_tick = 1'b1;
    end else begin
      n.ampc = q.ampc + 8'h01;
    end
    // Per-channel capture; a new pulse on a channel still waiting
    // to be stored is lost and flagged
    for (int c = 0; c < `SRHB_NCH; c++) begin
      n.prev[c] = hit[c] & ~q.dis[c];
      if (q.dis[c]) begin
        n.act[c] = 1'b0;
      end else if (hit[c] & ~q.prev[c]) begin
        if (q.pend[c]) begin
          ovf_set = 1'b1;
        end else begin
          n.act[c] = 1'b1;
          n.cts[c] = q.ts;
          n.cnt[c] = 4'h0;
        end
      end else if (~hit[c] & q.prev[c] & q.act[c]) begin
        n.act[c]  = 1'b0;
        n.pend[c] = 1'b1;
      end else if (q.act[c] & q.amp_tick & (q.cnt[c] != 4'hf)) begin
        n.cnt[c] = q.cnt[c] + 4'h1;
      end
    end
    for (int c = 0; c < `SRHB_NCH; c++) begin
      if (!found && q.pend[c]) begin
        found = 1'b1;
        sel   = 7'(c);
      end
    end
    push        = found & ~full;
    wdata.strip = sel;
    wdata.amp   = q.cnt[sel];
    wdata.ts    = q.cts[sel];
    wdata.t     = q.now;
    if (push) begin
      n.pend[sel] = 1'b0;
    end
    // Readout sequencer
    case (q.st)
      srhb_pkg::SRHB_IDLE: begin
        if (q.push_mode) begin
          if (!empty) begin
            n.st = srhb_pkg::SRHB_PUSH;
          end
        end else if ((q.tqn != 3'h0) && !q.wv) begin
          start  = 1'b1;
          n.wv   = 1'b1;
          n.word = ts_word(q.tq[0]);
          n.idx  = '0;
          n.st   = srhb_pkg::SRHB_SCAN;
        end else if (!empty &&
                     ((q.now - head.t) > 16'(`SRHB_LAT_CYC))) begin
          expire = 1'b1;
          pop    = 1'b1;
        end
      end
      srhb_pkg::SRHB_SCAN: begin
        if ((AW+1)'(q.idx) == count) begin
          tpop = 1'b1;
          n.st = srhb_pkg::SRHB_IDLE;
        end else if (rd.ts != q.tq[0]) begin
          n.idx = q.idx + AW'(1);
        end else if (!q.wv) begin
          load_hit = 1'b1;
          n.wv     = 1'b1;
          n.word   = hit_word(rd.strip, rd.amp);
          n.idx    = q.idx + AW'(1);
        end
      end
      srhb_pkg::SRHB_PUSH: begin
        if (!q.push_mode || empty) begin
          n.last_ok = 1'b0;
          n.st      = srhb_pkg::SRHB_IDLE;
        end else if (!q.wv) begin
          n.wv = 1'b1;
          if (!q.last_ok || (head.ts != q.last_ts)) begin
            n.word    = ts_word(head.ts);
            n.last_ts = head.ts;
            n.last_ok = 1'b1;
          end else begin
            n.word = hit_word(head.strip, head.amp);
            pop    = 1'b1;
          end
        end
      end
      default: begin
        n.st = srhb_pkg::SRHB_IDLE;
      end
    endcase
    // Trigger queue
    if (tpop) begin
      for (int i = 0; i < `SRHB_TQ_DEPTH - 1; i++) begin
        n.tq[i] = q.tq[i+1];
      end
    end
    tqa   = q.tqn - 3'(tpop);
    n.tqn = tqa;
    if (trig) begin
      if (tqa < 3'(`SRHB_TQ_DEPTH)) begin
        n.tq[tqa[1:0]] = trig_ts;
        n.tqn          = tqa + 3'h1;
      end else begin
        n.tlost = 1'b1;
      end
    end
    // Serializer: L lanes, lane l carries bit l of each chunk
    case (q.lanes)
      2'h0:    nl = 3'h1;
      2'h1:    nl = 3'h2;
      default: nl = 3'h4;
    endcase
    n.frame = 1'b0;
    if (q.bits != 5'h00) begin
      for (int l = 0; l < 4; l++) begin
        n.dout[l] = (3'(l) < nl) ? q.sr[l] : 1'b0;
      end
      n.sr   = q.sr >> nl;
      n.bits = q.bits - 5'(nl);
    end else if (q.wv) begin
      for (int l = 0; l < 4; l++) begin
        n.dout[l] = (3'(l) < nl) ? q.word[l] : 1'b0;
      end
      n.sr    = q.word >> nl;
      n.bits  = 5'h10 - 5'(nl);
      n.frame = 1'b1;
      n.wv    = 1'b0;
    end else begin
      n.dout = 4'h0;
    end
    // APB slave: answer in the access phase
    n.pready  = setup;
    n.pslverr = 1'b0;
    n.prdata  = 32'h0000_0000;
    n.test    = 1'b0;
    case (paddr)
      `SRHB_A_CTRL: begin
        rdv    = {27'h0, q.ampsel, q.lanes, q.push_mode};
        hit_ok = 1'b1;
      end
      `SRHB_A_STAT: begin
        rdv    = {16'h0, 2'h0, count, 5'h0, q.tlost, q.ovf,
                  (q.st != srhb_pkg::SRHB_IDLE) | q.wv};
        hit_ok = 1'b1;
      end
      `SRHB_A_TSNOW: begin
        rdv    = {22'h0, q.ts};
        hit_ok = 1'b1;
      end
      `SRHB_A_PULSE: begin
        hit_ok = 1'b1;
      end
      default: begin
        for (int k = 0; k < 4; k++) begin
          if (paddr == `SRHB_A_DIS0 + 12'(4 * k)) begin
            rdv    = q.dis[32*k +: 32];
            hit_ok = 1'b1;
          end
          if (paddr == `SRHB_A_INJ0 + 12'(4 * k)) begin
            rdv    = q.inj[32*k +: 32];
            hit_ok = 1'b1;
          end
        end
      end
    endcase
    if (setup) begin
      n.pslverr = ~hit_ok;
      n.prdata  = pwrite ? 32'h0000_0000 : rdv;
    end
    if (wr && hit_ok) begin
      case (paddr)
        `SRHB_A_CTRL: begin
          n.push_mode = pwdata[0];
          n.lanes     = pwdata[2:1];
          n.ampsel    = pwdata[4:3];
        end
        `SRHB_A_STAT: begin
          n.ovf   = q.ovf & ~pwdata[1];
          n.tlost = q.tlost & ~pwdata[2];
        end
        `SRHB_A_PULSE: begin
          n.test = pwdata[0];
        end
        default: begin
          for (int k = 0; k < 4; k++) begin
            if (paddr == `SRHB_A_DIS0 + 12'(4 * k)) begin
              n.dis[32*k +: 32] = pwdata;
            end
            if (paddr == `SRHB_A_INJ0 + 12'(4 * k)) begin
              n.inj[32*k +: 32] = pwdata;
            end
          end
        end
      endcase
    end
    // Hardware set wins over a software clear
    if (ovf_set) begin
      n.ovf = 1'b1;
    end
    if (trig && !(tqa < 3'(`SRHB_TQ_DEPTH))) begin
      n.tlost = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q           <= '0;
      q.st        <= srhb_pkg::SRHB_IDLE;
      q.push_mode <= 1'b0;
      q.lanes     <= 2'(`SRHB_CTRL_RST >> 1);
    end else begin
      q <= n;
    end
  end

  assign prdata      = q.prdata;
  assign pready      = q.pready;
  assign pslverr     = q.pslverr;
  assign dout        = q.dout;
  assign dout_frame  = q.frame;
  assign test_charge = q.test;
  assign inj_mask    = q.inj;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_hdr;
    q.wv && q.word[`SRHB_TYPE_BIT];
  endsequence

  sequence s_quiet3;
    !q.frame [*3];
  endsequence

  a_ts_advance: assert property ((q.tsc == 8'(`SRHB_TS_CYC - 1)) |=>
    (q.ts == 10'($past(q.ts) + 10'h001)))
    else $error("stamp counter did not advance");
  a_kill_chan: assert property ((q.dis[7] && !q.pend[7]) |=>
    (!q.pend[7] && !q.act[7]))
    else $error("disabled channel produced a hit");
  a_match_only: assert property (load_hit |-> (rd.ts == q.tq[0]))
    else $error("hit sent with wrong stamp");
  a_hdr_first: assert property (start |=> s_hdr)
    else $error("stamp word not sent first");
  a_spare_zero: assert property (q.wv |-> (q.word[15:12] == 4'h0))
    else $error("spare bits not zero");
  a_expire_drop: assert property (expire |=>
    (int'(count) == int'($past(count)) - 1 + int'($past(push))))
    else $error("expired hit not dropped");
  a_lane_four: assert property ((q.frame && q.lanes == 2'h2 &&
    q.bits == 5'h0c) |=> s_quiet3)
    else $error("four-lane word length wrong");
  a_cfg_keep: assert property ((wr && paddr == `SRHB_A_CTRL) |=>
    (q.lanes == $past(pwdata[2:1])) ##1
    (q.lanes == $past(pwdata[2:1], 2)))
    else $error("lane setting not kept");
  for (genvar c = 0; c < `SRHB_NCH; c++) begin : g_amp_chk
    a_amp_count: assert property (@(posedge pclk)
      disable iff (!presetn)
      (q.act[c] && q.amp_tick && hit[c] && q.prev[c] && !q.dis[c] &&
       q.cnt[c] != 4'hf) |=> (q.cnt[c] == 4'($past(q.cnt[c]) + 4'h1)))
      else $error("pulse width count did not step");
  end
endmodule : srhb_top

/* File: sim/srhb_daq_model.sv */
// Back-end model: trigger source and serial lane deserializer.
// Assumes the bench sets the lane count in use; single pclk domain.
`timescale 1ns/100ps
module srhb_daq_model (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [3:0]  dout,
  input  wire logic        dout_frame,
  input  wire logic [2:0]  lanes,
  output logic             trig,
  output logic      [9:0]  trig_ts,
  output logic      [15:0] word,
  output logic             word_vld
);
  logic [15:0] acc;
  logic        busy;
  int          k;

  initial begin
    trig    = 1'b0;
    trig_ts = 10'h000;
  end

  // One-cycle trigger; the stamp lines show garbage once released
  task automatic send_trig(input logic [9:0] ts);
    @(posedge pclk);
    trig    <= 1'b1;
    trig_ts <= ts;
    @(posedge pclk);
    trig    <= 1'b0;
    trig_ts <= ~ts;
  endtask : send_trig

  // *************************************************************
  // Word assembly: chunk k, lane l carries bit k*lanes+l
  // *************************************************************
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy     = 1'b0;
      k        = 0;
      acc      = 16'h0000;
      word     <= 16'h0000;
      word_vld <= 1'b0;
    end else begin
      word_vld <= 1'b0;
      if (dout_frame === 1'b1) begin
        busy = 1'b1;
        k    = 0;
      end
      if (busy) begin
        for (int l = 0; l < 4; l++) begin
          if (l < lanes) acc[k*lanes+l] = dout[l];
        end
        k++;
        if (k * lanes >= 16) begin
          word     <= acc;
          word_vld <= 1'b1;
          busy     = 1'b0;
        end
      end
    end
  end
endmodule : srhb_daq_model

/* File: sim/tb_top.sv */
// Self-checking bench for the strip readout hit buffer.
// Assumes the design files and the back-end model compiled first.
`timescale 1ns/100ps
`include "srhb_params.svh"
module tb_top;
  logic          pclk, presetn, psel, penable, pwrite;
  logic [11:0]   paddr;
  logic [31:0]   pwdata, prdata;
  logic          pready, pslverr, trig, dout_frame, test_charge;
  logic [127:0]  hit, inj_mask;
  logic [9:0]    trig_ts;
  logic [3:0]    dout;
  logic [15:0]   word;
  logic          word_vld;
  logic [2:0]    lanes;
  logic [15:0]   exp_q[$];
  int            cyc, tc_cnt, num_errors, num_checks;

  srhb_top #(.DEPTH(32), .AW(5)) dut (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .hit, .trig,
    .trig_ts, .dout, .dout_frame, .test_charge, .inj_mask);

  srhb_daq_model daq (.pclk, .presetn, .dout, .dout_frame, .lanes,
    .trig, .trig_ts, .word, .word_vld);

  initial pclk = 1'b0;
  always #25 pclk = ~pclk;

  task automatic tally_and_finish();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : tally_and_finish

  task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                       input string msg);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("FAIL %0t %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask : check

  // *************************************************************
  // Monitors: cycle count, timeout, output words, test pulses
  // *************************************************************
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (test_charge === 1'b1) tc_cnt++;
    if (cyc == 30000) begin
      num_errors++;
      tally_and_finish();
    end
  end

  always @(posedge pclk) begin
    if (word_vld === 1'b1) begin
      if (exp_q.size() == 0) check(32'h1, 32'h0, "extra word");
      else check(32'(word), 32'(exp_q.pop_front()), "word");
    end
  end

  // *************************************************************
  // Bus and scenario tasks
  // *************************************************************
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d, output logic [31:0] rd,
                     output logic err, output int e);
    int n;
    n = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    e = cyc;
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1);
    check(32'(n), 32'h1, "pready wait");
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    pwdata  <= ~d;
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        err;
    int          e;
    apb(1'b1, a, d, r, err, e);
  endtask : wr

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] x,
                        input logic xerr);
    logic [31:0] r;
    logic        err;
    int          e;
    apb(1'b0, a, 32'h0, r, err, e);
    check(r, x, "read data");
    check(32'(err), 32'(xerr), "slave error");
  endtask : rd_chk

  task automatic drain();
    int n;
    n = 0;
    while (exp_q.size() != 0 && n < 1000) begin
      @(posedge pclk);
      n++;
    end
    check(32'(exp_q.size()), 32'h0, "words missing");
    repeat (20) @(posedge pclk);
  endtask : drain

  // Hits on two strips at one stamp, one strip later, one disabled
  task automatic burst(input logic [1:0] code, input logic [2:0] nl,
                       input int gap);
    logic [31:0] r;
    logic        err;
    int          e, h;
    logic [9:0]  t0;
    logic [6:0]  s1, s2, s3;
    s1 = 7'(8 + $urandom % 20);
    s2 = 7'(64 + $urandom % 60);
    s3 = 7'(32 + $urandom % 30);
    wr(`SRHB_A_CTRL, {29'h0, code, 1'b0});
    lanes = nl;
    apb(1'b0, `SRHB_A_TSNOW, 32'h0, r, err, e);
    @(posedge pclk);
    hit <= (128'h1 << s1) | (128'h1 << s2) | (128'h1 << 7);
    h = cyc + 1;
    repeat (3) @(posedge pclk);
    hit <= hit | (128'h1 << s3);
    repeat (20) @(posedge pclk);
    hit <= '0;
    repeat (gap) @(posedge pclk);
    t0 = 10'(r[9:0] + 10'(h - e));
    exp_q.push_back({6'h02, t0});
    if (gap < 140) begin
      exp_q.push_back({5'h00, 4'hf, s1});
      exp_q.push_back({5'h00, 4'hf, s2});
    end
    exp_q.push_back({6'h02, 10'(t0 + 10'h003)});
    if (gap < 140) exp_q.push_back({5'h00, 4'hf, s3});
    daq.send_trig(t0);
    daq.send_trig(10'(t0 + 10'h003));
    drain();
  endtask : burst

  initial begin
    logic [31:0] v, r1, r2;
    logic        err;
    int          e1, e2;
    logic [6:0]  sp;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    hit = '0;
    lanes = 3'd4;
    presetn = 1'b0;
    cyc = 0;
    tc_cnt = 0;
    num_errors = 0;
    num_checks = 0;
    void'($urandom(32'h9431c8ef));
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    rd_chk(`SRHB_A_CTRL, `SRHB_CTRL_RST, 1'b0);
    for (int i = 0; i < 4; i++) begin
      rd_chk(`SRHB_A_DIS0 + 12'(4*i), 32'h0, 1'b0);
      rd_chk(`SRHB_A_INJ0 + 12'(4*i), 32'h0, 1'b0);
      v = $urandom;
      wr(`SRHB_A_INJ0 + 12'(4*i), v);
      wr(`SRHB_A_DIS0 + 12'(4*i), ~v);
      rd_chk(`SRHB_A_INJ0 + 12'(4*i), v, 1'b0);
      rd_chk(`SRHB_A_DIS0 + 12'(4*i), ~v, 1'b0);
      check(inj_mask[32*i +: 32], v, "inj mask");
      wr(`SRHB_A_DIS0 + 12'(4*i), 32'h0);
    end
    v = $urandom;
    wr(`SRHB_A_CTRL, v);
    rd_chk(`SRHB_A_CTRL, v & 32'h1f, 1'b0);
    rd_chk(12'h0f0, 32'h0, 1'b1);
    wr(`SRHB_A_PULSE, 32'h1);
    repeat (3) @(posedge pclk);
    check(32'(tc_cnt), 32'h1, "test pulse");
    rd_chk(`SRHB_A_PULSE, 32'h0, 1'b0);
    apb(1'b0, `SRHB_A_TSNOW, 32'h0, r1, err, e1);
    apb(1'b0, `SRHB_A_TSNOW, 32'h0, r2, err, e2);
    check(r2, 32'(10'(r1[9:0] + 10'(e2 - e1))), "stamp step");
    wr(`SRHB_A_DIS0, 32'h80);
    burst(2'd0, 3'd1, 10);
    burst(2'd1, 3'd2, 90);
    burst(2'd2, 3'd4, 10);
    burst(2'd3, 3'd4, 200);
    rd_chk(`SRHB_A_STAT, 32'h0, 1'b0);
    // Push mode: one hit streams out with no trigger
    sp = 7'(8 + $urandom % 100);
    wr(`SRHB_A_CTRL, 32'h5);
    apb(1'b0, `SRHB_A_TSNOW, 32'h0, r1, err, e1);
    @(posedge pclk);
    hit <= 128'h1 << sp;
    e2 = cyc + 1;
    repeat (20) @(posedge pclk);
    hit <= '0;
    exp_q.push_back({6'h02, 10'(r1[9:0] + 10'(e2 - e1))});
    exp_q.push_back({5'h00, 4'hf, sp});
    drain();
    tally_and_finish();
  end
endmodule : tb_top
